// [logic/spi_cmd_consts.vh]
// constants for the serial memory command front end
`ifndef SPI_CMD_CONSTS_VH
`define SPI_CMD_CONSTS_VH
`define OP_SET_WRITE_LATCH 8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_MEM_WRITE 8'h02
`define OP_SLEEP 8'hB9
`define OP_IDENT_READ 8'h9F
`define CMD_NONE 4'h0
`define CMD_SET_WL 4'h1
`define CMD_CLR_WL 4'h2
`define CMD_SR_READ 4'h3
`define CMD_SR_WRITE 4'h4
`define CMD_MEM_READ 4'h5
`define CMD_FAST_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_SLEEP 4'h8
`define CMD_IDENT 4'h9
`define CMD_INVALID 4'hF
`define STATUS_LATCH_BIT 1
`define STATUS_RESET 8'h00
`define ADDR_BITS 14
`define POWER_UP_WAIT_US 250
`define CLK_MHZ 100
`define POWER_UP_CYCLES (`POWER_UP_WAIT_US * `CLK_MHZ)
`endif

// [logic/opcode_decode.v]
// opcode byte to command code decoder
`timescale 1ns/1ns
`include "spi_cmd_consts.vh"
module opcode_decode (
    input wire [7:0] opcode_in,
    output reg [3:0] cmd_out
);
    always @* begin
        case (opcode_in)
            `OP_SET_WRITE_LATCH: cmd_out = `CMD_SET_WL;
            `OP_CLEAR_WRITE_LATCH: cmd_out = `CMD_CLR_WL;
            `OP_STATUS_READ: cmd_out = `CMD_SR_READ;
            `OP_STATUS_WRITE: cmd_out = `CMD_SR_WRITE;
            `OP_MEM_READ: cmd_out = `CMD_MEM_READ;
            `OP_FAST_READ: cmd_out = `CMD_FAST_READ;
            `OP_MEM_WRITE: cmd_out = `CMD_MEM_WRITE;
            `OP_SLEEP: cmd_out = `CMD_SLEEP;
            `OP_IDENT_READ: cmd_out = `CMD_IDENT;
            // reserved codes fall here too
            default: cmd_out = `CMD_INVALID;
        endcase
    end
endmodule

// [logic/spi_cmd_front.v]
// serial command front end: framing, decode, write latch, status
`timescale 1ns/1ns
`include "spi_cmd_consts.vh"
module spi_cmd_front #(
    parameter POWER_UP_CYCLES = `POWER_UP_CYCLES
) (
    input wire clk_in,
    input wire rst_in,
    input wire sck_in,
    input wire cs_n_in,
    input wire si_in,
    input wire [7:0] sr_read_data_in,
    output reg so_out,
    output reg so_oe_out,
    output reg ready_out,
    output reg mode3_out,
    output reg [3:0] cmd_out,
    output reg cmd_valid_out,
    output reg [13:0] addr_out,
    output reg addr_valid_out,
    output reg [7:0] data_out,
    output reg data_valid_out,
    output reg latch_flag_out,
    output reg [7:0] status_out
);
    localparam ST_IDLE = 3'd0;
    localparam ST_OPCODE = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_STATUS = 3'd4;
    localparam ST_IGNORE = 3'd5;
    localparam ST_DONE = 3'd6;

    reg sck_s1_r, sck_s2_r, sck_d_r;
    reg cs_s1_r, cs_s2_r, cs_d_r;
    reg si_s1_r, si_s2_r;
    reg [2:0] state_r;
    reg [2:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg addr_hi_r;
    reg [7:0] addr_hi_byte_r;
    reg [3:0] cmd_r;
    reg armed_r;
    reg [7:0] tx_r;
    reg latch_r;
    reg [15:0] pu_cnt_r;
    wire [3:0] dec_cmd;
    wire sck_rise;
    wire sck_fall;
    wire cs_fall;
    wire cs_rise;
    wire [7:0] byte_in;
    wire byte_done;

    // pins cross from the master's timing into ours
    always @(posedge clk_in) begin
        if (rst_in) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_d_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r <= 1'b1;
            si_s1_r <= 1'b0;
            si_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_d_r <= sck_s2_r;
            cs_s1_r <= cs_n_in;
            cs_s2_r <= cs_s1_r;
            cs_d_r <= cs_s2_r;
            si_s1_r <= si_in;
            si_s2_r <= si_s1_r;
        end
    end

    assign sck_rise = sck_s2_r & ~sck_d_r & ~cs_s2_r & ready_out;
    assign sck_fall = ~sck_s2_r & sck_d_r & ~cs_s2_r & ready_out;
    assign cs_fall = ~cs_s2_r & cs_d_r & ready_out;
    assign cs_rise = cs_s2_r & ~cs_d_r;
    assign byte_in = {shift_r[6:0], si_s2_r};
    // eighth armed rise completes the byte
    assign byte_done = sck_rise & armed_r & (bit_cnt_r == 3'd7);

    opcode_decode u_dec (
        .opcode_in(byte_in),
        .cmd_out(dec_cmd)
    );

    // power-up gate: selects before it expires are ignored
    always @(posedge clk_in) begin
        if (rst_in) begin
            pu_cnt_r <= 16'h0000;
            ready_out <= 1'b0;
        end else if (pu_cnt_r == POWER_UP_CYCLES[15:0]) begin
            ready_out <= 1'b1;
        end else begin
            pu_cnt_r <= pu_cnt_r + 16'h0001;
        end
    end

    // framing and decode
    always @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'd0;
            shift_r <= 8'h00;
            addr_hi_r <= 1'b0;
            addr_hi_byte_r <= 8'h00;
            cmd_r <= `CMD_NONE;
            armed_r <= 1'b0;
            mode3_out <= 1'b0;
            cmd_out <= `CMD_NONE;
            cmd_valid_out <= 1'b0;
            addr_out <= 14'h0000;
            addr_valid_out <= 1'b0;
            data_out <= 8'h00;
            data_valid_out <= 1'b0;
        end else begin
            cmd_valid_out <= 1'b0;
            addr_valid_out <= 1'b0;
            data_valid_out <= 1'b0;
            if (cs_fall) begin
                state_r <= ST_OPCODE;
                bit_cnt_r <= 3'd0;
                shift_r <= 8'h00;
                cmd_r <= `CMD_NONE;
                addr_hi_r <= 1'b0;
                // clock level at select picks mode
                mode3_out <= sck_s2_r;
                // mode 3 waits for the first falling toggle
                armed_r <= ~sck_s2_r;
            end else if (cs_s2_r) begin
                state_r <= ST_IDLE;
                armed_r <= 1'b0;
            end else begin
                if (sck_fall)
                    armed_r <= 1'b1;
                // input sampled on rising edge only
                if (sck_rise && armed_r && state_r != ST_IGNORE &&
                        state_r != ST_IDLE) begin
                    shift_r <= byte_in;
                    bit_cnt_r <= bit_cnt_r + 3'd1;
                end
                if (byte_done) begin
                    case (state_r)
                        ST_OPCODE: begin
                            cmd_r <= dec_cmd;
                            cmd_out <= dec_cmd;
                            cmd_valid_out <= 1'b1;
                            case (dec_cmd)
                                `CMD_INVALID: state_r <= ST_IGNORE;
                                `CMD_MEM_READ, `CMD_FAST_READ,
                                `CMD_MEM_WRITE: state_r <= ST_ADDR;
                                `CMD_SR_WRITE, `CMD_SR_READ,
                                `CMD_IDENT: state_r <= ST_DATA;
                                default: state_r <= ST_DONE;
                            endcase
                        end
                        ST_ADDR: begin
                            if (!addr_hi_r) begin
                                addr_hi_r <= 1'b1;
                                addr_hi_byte_r <= byte_in;
                            end else begin
                                addr_out <= {addr_hi_byte_r[5:0], byte_in};
                                addr_valid_out <= 1'b1;
                                state_r <= ST_DATA;
                            end
                        end
                        ST_DATA: begin
                            data_out <= byte_in;
                            data_valid_out <= 1'b1;
                        end
                        default: state_r <= state_r;
                    endcase
                end
            end
        end
    end

    // status image with latch flag in bit one
    always @(posedge clk_in) begin
        if (rst_in) begin
            latch_r <= 1'b0;
            latch_flag_out <= 1'b0;
            status_out <= `STATUS_RESET;
        end else begin
            // set opcode sets latch on decode
            if (byte_done && state_r == ST_OPCODE &&
                    dec_cmd == `CMD_SET_WL)
                latch_r <= 1'b1;
            // clear at the deselect ending these commands
            else if (cs_rise && (cmd_r == `CMD_CLR_WL ||
                    cmd_r == `CMD_SR_WRITE || cmd_r == `CMD_MEM_WRITE))
                latch_r <= 1'b0;
            latch_flag_out <= latch_r;
            // written status byte never touches latch bit
            status_out <= {sr_read_data_in[7:2], latch_r, 1'b0};
        end
    end

    // output shifter; off unless a status read is framed
    always @(posedge clk_in) begin
        if (rst_in) begin
            tx_r <= 8'h00;
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
        end else if (cs_s2_r || state_r == ST_IGNORE) begin
            so_oe_out <= 1'b0;
            so_out <= 1'b0;
        end else if (byte_done && state_r == ST_OPCODE &&
                dec_cmd == `CMD_SR_READ) begin
            tx_r <= {sr_read_data_in[7:2], latch_r, 1'b0};
        end else if (sck_fall && cmd_r == `CMD_SR_READ) begin
            so_oe_out <= 1'b1;
            so_out <= tx_r[7];
            tx_r <= {tx_r[6:0], tx_r[7]};
        end
    end
endmodule

// [bench/spi_cmd_front_checker.sv]
// assertion checker for the serial command front end
`timescale 1ns/1ns
`include "spi_cmd_consts.vh"
module spi_cmd_front_checker (
    input wire clk_in,
    input wire rst_in,
    input wire cs_n_in,
    input wire so_oe_out,
    input wire ready_out,
    input wire [3:0] cmd_out,
    input wire cmd_valid_out,
    input wire addr_valid_out,
    input wire data_valid_out,
    input wire latch_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_RESET_CLEAR: assert property ($fell(rst_in) |-> !latch_flag_out
        && cmd_out == `CMD_NONE) else $error("state left after reset");
    AST_PULSE: assert property (cmd_valid_out |=> !cmd_valid_out)
        else $error("command strobe too long");
    AST_NOT_READY: assert property (!ready_out |-> !cmd_valid_out)
        else $error("command taken before ready");
    AST_SET: assert property (cmd_valid_out && cmd_out == `CMD_SET_WL
        |-> ##[0:3] latch_flag_out) else $error("latch not set");
    AST_ONLY_SET: assert property ($rose(latch_flag_out)
        |-> cmd_out == `CMD_SET_WL) else $error("latch set by other");
    AST_CLEAR: assert property ($rose(cs_n_in) && (cmd_out == `CMD_CLR_WL
        || cmd_out == `CMD_SR_WRITE || cmd_out == `CMD_MEM_WRITE)
        |-> ##[1:8] !latch_flag_out) else $error("latch not cleared");
    AST_INVALID: assert property (cmd_out == `CMD_INVALID |-> !so_oe_out
        && !addr_valid_out && !data_valid_out) else $error("bad opcode used");
    AST_DESELECT: assert property (cs_n_in [*6] |-> !so_oe_out)
        else $error("output driven while deselected");
endmodule
bind spi_cmd_front spi_cmd_front_checker chk (.clk_in(clk_in),
    .rst_in(rst_in), .cs_n_in(cs_n_in), .so_oe_out(so_oe_out),
    .ready_out(ready_out), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
    .addr_valid_out(addr_valid_out), .data_valid_out(data_valid_out),
    .latch_flag_out(latch_flag_out));

// [bench/spi_master_model.sv]
// serial bus master model driving the command front end
`timescale 1ns/1ns
module spi_master_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire so_in
);
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // rx keeps the last eight bits seen, sampled late in the high phase
    task automatic frame(input bit m3, input logic [31:0] d,
        input int nbits, output logic [7:0] rx);
        sck_out <= m3;
        #80 cs_n_out <= 1'b0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            sck_out <= 1'b0;
            si_out <= d[31-i];
            #40 sck_out <= 1'b1;
            #39 rx = {rx[6:0], so_in};
            #1;
        end
        sck_out <= m3;
        #80 cs_n_out <= 1'b1;
        // released line must not keep the last bit
        si_out <= ~si_out;
        #200;
    endtask
endmodule

// [bench/test_spi_cmd_front.sv]
// self-checking bench for the serial command front end
`timescale 1ns/1ns
`include "spi_cmd_consts.vh"
module test_spi_cmd_front;
    logic clk_in, rst_in;
    logic [7:0] sr_in, rx;
    logic [3:0] last_cmd;
    wire sck, cs_n, si, so, so_oe, ready, mode3, cmd_valid, addr_valid;
    wire data_valid, latch;
    wire [3:0] cmd;
    wire [13:0] addr;
    wire [7:0] data, status;
    wire so_line;
    int err_total, comparisons, cycles, n_cmd, n_data, nd;
    logic [7:0] ops [10] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B,
        8'h02, 8'hB9, 8'h9F, 8'h00};
    logic [3:0] exp_cmd [10] = '{`CMD_SET_WL, `CMD_CLR_WL, `CMD_SR_READ,
        `CMD_SR_WRITE, `CMD_MEM_READ, `CMD_FAST_READ, `CMD_MEM_WRITE,
        `CMD_SLEEP, `CMD_IDENT, `CMD_INVALID};
    spi_cmd_front #(.POWER_UP_CYCLES(10)) dut (.clk_in(clk_in),
        .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .sr_read_data_in(sr_in), .so_out(so), .so_oe_out(so_oe),
        .ready_out(ready), .mode3_out(mode3), .cmd_out(cmd),
        .cmd_valid_out(cmd_valid), .addr_out(addr),
        .addr_valid_out(addr_valid), .data_out(data),
        .data_valid_out(data_valid), .latch_flag_out(latch),
        .status_out(status));
    spi_master_model m (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
        .so_in(so_line));
    // released line reads inverted, so a missing enable shows up
    assign so_line = so_oe ? so : ~so;
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic check(input string name, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard, far above the few thousand cycles needed
    always @(posedge clk_in) begin
        cycles++;
        if (cmd_valid) begin
            n_cmd++;
            last_cmd <= cmd;
        end
        if (data_valid) n_data++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish;
        end
    end
    initial begin
        rst_in = 1'b1;
        sr_in = 8'hA4;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        while (ready !== 1'b1) @(posedge clk_in);
        check("latch", 16'(latch), 16'h0);
        for (int i = 0; i < 10; i++) begin
            m.frame(i[0], {ops[i], 24'h0}, 8, rx);
            check("cmd", 16'(last_cmd), 16'(exp_cmd[i]));
            check("mode3", 16'(mode3), 16'(i[0]));
        end
        check("count", 16'(n_cmd), 16'hA);
        m.frame(0, 32'h0600_0000, 8, rx);
        check("latch", 16'(latch), 16'h1);
        m.frame(1, 32'h0500_0000, 16, rx);
        check("status", 16'(rx), 16'hA6);
        check("status_out", 16'(status), 16'hA6);
        m.frame(0, 32'h01FF_0000, 16, rx);
        check("data", 16'(data), 16'hFF);
        check("latch", 16'(latch), 16'h0);
        m.frame(1, 32'h0600_0000, 8, rx);
        m.frame(0, 32'h02C1_235A, 32, rx);
        check("addr", 16'(addr), 16'h0123);
        check("data", 16'(data), 16'h5A);
        check("latch", 16'(latch), 16'h0);
        m.frame(0, 32'h0600_0000, 8, rx);
        m.frame(1, 32'h0400_0000, 8, rx);
        m.frame(0, 32'h0500_0000, 16, rx);
        check("status", 16'(rx), 16'hA4);
        // top address bits sent as zero
        m.frame(0, 32'h033F_FF00, 24, rx);
        check("addr", 16'(addr), 16'h3FFF);
        nd = n_data;
        m.frame(0, 32'h0005_5AA5, 32, rx);
        check("pulses", 16'(n_data), 16'(nd));
        m.frame(0, 32'hFF00_0000, 3, rx);
        m.frame(1, 32'h0600_0000, 8, rx);
        check("cmd", 16'(last_cmd), 16'(`CMD_SET_WL));
        tally_and_finish;
    end
endmodule
